/* File: hw/dac_sleep_output_disable.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Mode value 3 enters full power down
// R2 - Power down keeps residual output alive
// R3 - Wake takes hundreds of microseconds
// R4 - Waveform select 6 disables one channel
// R5 - Gate off forces midscale sample code
// R6 - Non-silent gating keeps residual output
// R7 - Silent gating removes residual, aging caveat
// R8 - Sleep bias at bits 7:4 of 0x724/0x726
// R9 - Software computes sleep bias from termination
// R10 - Gate combines pin and register bit
module dac_sleep_output_disable #(
	parameter int DATA_W = 16,
	parameter int WAKE_COUNT = dac_sleep_pkg::WAKE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [11:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// Control fields from other configuration registers
	input wire logic [1:0] deviceMode,
	input wire logic [2:0] outputWaveformSelectA,
	input wire logic [2:0] outputWaveformSelectB,
	input wire logic [1:0] gateRegBits,
	input wire logic silentGateControl,
	input wire logic [1:0] elementMatchingSetting,
	input wire logic [1:0] ditherSetting,
	// Transmit gate pins, asynchronous
	input wire logic [1:0] transmitGatePins,
	// Samples
	input wire logic [DATA_W-1:0] sampleA,
	input wire logic [DATA_W-1:0] sampleB,
	output logic [DATA_W-1:0] codeA,
	output logic [DATA_W-1:0] codeB,
	output dac_sleep_pkg::chan_ctrl_t ctrlA,
	output dac_sleep_pkg::chan_ctrl_t ctrlB,
	output logic powerDown,
	output logic outputReady
);
	logic [1:0] pinMeta; // First stage, read only by pinSync
	logic [1:0] pinSync;
	logic [7:0] biasA;
	logic [7:0] biasB;
	dac_sleep_pkg::power_state_t pwrState;
	logic [31:0] wakeCount;

	// Two-stage sync on the gate pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pinMeta <= 2'h0;
			pinSync <= 2'h0;
		end else begin
			pinMeta <= transmitGatePins;
			pinSync <= pinMeta;
		end
	end

	// Sleep bias registers; only the upper nibble is used
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			biasA <= dac_sleep_pkg::BIAS_RESET;
			biasB <= dac_sleep_pkg::BIAS_RESET;
		end else if (regWrite) begin
			if (regAddr == dac_sleep_pkg::SLEEP_BIAS_A_ADDR) begin
				biasA <= regWdata; // [R8]
			end
			if (regAddr == dac_sleep_pkg::SLEEP_BIAS_B_ADDR) begin
				biasB <= regWdata; // [R8]
			end
		end
	end

	// Read data registered; unmapped reads return zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			regRdata <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				dac_sleep_pkg::SLEEP_BIAS_A_ADDR: begin
					regRdata <= biasA;
				end
				dac_sleep_pkg::SLEEP_BIAS_B_ADDR: begin
					regRdata <= biasB;
				end
				default: begin
					regRdata <= 8'h00;
				end
			endcase
		end
	end

	// Power state: down on mode 3, timed wake afterwards
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwrState <= dac_sleep_pkg::PWR_ACTIVE;
			wakeCount <= 32'h0000_0000;
		end else begin
			case (pwrState)
				dac_sleep_pkg::PWR_ACTIVE: begin
					if (deviceMode == dac_sleep_pkg::MODE_POWER_DOWN) begin
						pwrState <= dac_sleep_pkg::PWR_DOWN; // [R1]
					end
				end
				dac_sleep_pkg::PWR_DOWN: begin
					if (deviceMode != dac_sleep_pkg::MODE_POWER_DOWN) begin
						pwrState <= dac_sleep_pkg::PWR_WAKING;
						wakeCount <= 32'h0000_0000;
					end
				end
				dac_sleep_pkg::PWR_WAKING: begin
					// Output stays invalid until the wake time passes
					if (deviceMode == dac_sleep_pkg::MODE_POWER_DOWN) begin
						pwrState <= dac_sleep_pkg::PWR_DOWN;
					end else if (wakeCount >= 32'(WAKE_COUNT - 1)) begin
						pwrState <= dac_sleep_pkg::PWR_ACTIVE; // [R3]
					end else begin
						wakeCount <= wakeCount + 32'h0000_0001;
					end
				end
				default: begin
					pwrState <= dac_sleep_pkg::PWR_ACTIVE;
				end
			endcase
		end
	end

	assign powerDown = (pwrState == dac_sleep_pkg::PWR_DOWN);
	assign outputReady = (pwrState == dac_sleep_pkg::PWR_ACTIVE); // [R3]

	// Channel A
	dac_channel_gate #(.DATA_W(DATA_W)) chanA (
		.ref_clk(ref_clk),
		.rst(rst),
		.gatePinSync(pinSync[0]),
		.gateReg(gateRegBits[0]),
		.outputWaveformSelect(outputWaveformSelectA),
		.silentGateControl(silentGateControl),
		.elementMatchingSetting(elementMatchingSetting),
		.ditherSetting(ditherSetting),
		.powerDown(powerDown),
		.sleepBiasCurrent(biasA[dac_sleep_pkg::BIAS_MSB:dac_sleep_pkg::BIAS_LSB]),
		.sampleIn(sampleA),
		.sampleOut(codeA),
		.ctrl(ctrlA)
	);

	// Channel B
	dac_channel_gate #(.DATA_W(DATA_W)) chanB (
		.ref_clk(ref_clk),
		.rst(rst),
		.gatePinSync(pinSync[1]),
		.gateReg(gateRegBits[1]),
		.outputWaveformSelect(outputWaveformSelectB),
		.silentGateControl(silentGateControl),
		.elementMatchingSetting(elementMatchingSetting),
		.ditherSetting(ditherSetting),
		.powerDown(powerDown),
		.sleepBiasCurrent(biasB[dac_sleep_pkg::BIAS_MSB:dac_sleep_pkg::BIAS_LSB]),
		.sampleIn(sampleB),
		.sampleOut(codeB),
		.ctrl(ctrlB)
	);

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_gateOff;
		!(pinSync[0] && gateRegBits[0]);
	endsequence

	// Channel B gate, checked on its own so the channels stay independent
	sequence s_gateOffB;
		!(pinSync[1] && gateRegBits[1]);
	endsequence

	// Power and wake checks

	a_mode_enters_down: assert property ((deviceMode == dac_sleep_pkg::MODE_POWER_DOWN) |=> powerDown) // [R1]
		else $error("Mode 3 did not power down");
	a_down_residual: assert property (powerDown |=> (ctrlA.residualOn && ctrlB.residualOn)) // [R2]
		else $error("Residual lost in power down");
	a_wake_not_ready: assert property ($fell(powerDown) |-> !outputReady [*8]) // [R3]
		else $error("Ready too soon after wake");

	// Channel A: disable, gating and residual
	// Silent gating on a disabled channel drops the residual, so it is left out here
	a_disable_chan: assert property ((outputWaveformSelectA == dac_sleep_pkg::WAVE_DISABLED
		&& ((pinSync[0] && gateRegBits[0]) || !silentGateControl)) |=> (!ctrlA.outputOn && ctrlA.residualOn)) // [R4]
		else $error("Channel A not disabled");
	a_gate_midscale: assert property (s_gateOff |=> (codeA == dac_sleep_pkg::MIDSCALE_CODE)) // [R5] [R10]
		else $error("Gated code not midscale");
	a_gate_passes: assert property ((pinSync[0] && gateRegBits[0]) |=> (codeA == $past(sampleA))) // [R10]
		else $error("Open gate did not pass sample");
	a_loud_residual: assert property ((s_gateOff ##0 !silentGateControl) |=> ctrlA.residualOn) // [R6]
		else $error("Residual missing while gated");
	a_silent_quiet: assert property ((s_gateOff ##0 silentGateControl && !powerDown) |=> !ctrlA.residualOn) // [R7]
		else $error("Silent gate left residual");
	// Data dependent settings under silent gating age the output stage
	a_aging_flag: assert property ((s_gateOff ##0 silentGateControl && !powerDown
		&& (elementMatchingSetting[1] || ditherSetting[1])) |=> ctrlA.agingRisk) // [R7]
		else $error("Aging risk not flagged");
	a_aging_safe: assert property ((!elementMatchingSetting[1] && !ditherSetting[1]) |=> !ctrlA.agingRisk) // [R7]
		else $error("Aging risk flagged wrongly");

	// Channel B: disable and gating
	a_disable_chanb: assert property ((outputWaveformSelectB == dac_sleep_pkg::WAVE_DISABLED)
		|=> !ctrlB.outputOn) // [R4]
		else $error("Channel B not disabled");
	a_gateb_midscale: assert property (s_gateOffB |=> (codeB == dac_sleep_pkg::MIDSCALE_CODE)) // [R5] [R10]
		else $error("Gated B code not midscale");
	a_gateb_passes: assert property ((pinSync[1] && gateRegBits[1]) |=> (codeB == $past(sampleB))) // [R10]
		else $error("Open gate B did not pass sample");

	// Register fields reach the output stage two cycles after the write
	a_bias_write: assert property ((regWrite && regAddr == dac_sleep_pkg::SLEEP_BIAS_A_ADDR)
		|=> ##1 (ctrlA.sleepBias == $past(regWdata[dac_sleep_pkg::BIAS_MSB:dac_sleep_pkg::BIAS_LSB], 2))) // [R8]
		else $error("Bias A field not applied");
	a_bias_write_b: assert property ((regWrite && regAddr == dac_sleep_pkg::SLEEP_BIAS_B_ADDR)
		|=> ##1 (ctrlB.sleepBias == $past(regWdata[dac_sleep_pkg::BIAS_MSB:dac_sleep_pkg::BIAS_LSB], 2))) // [R8]
		else $error("Bias B field not applied");
endmodule
`default_nettype wire

/* File: hw/dac_sleep_pkg.sv */
package dac_sleep_pkg;
	// Register offsets for the sleep bias fields
	localparam logic [11:0] SLEEP_BIAS_A_ADDR = 12'h0724;
	localparam logic [11:0] SLEEP_BIAS_B_ADDR = 12'h0726;
	// Sleep bias field position inside its register
	localparam int BIAS_MSB = 7;
	localparam int BIAS_LSB = 4;
	localparam logic [7:0] BIAS_RESET = 8'h00;
	// Device mode and output waveform codes
	localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
	localparam logic [2:0] WAVE_DISABLED = 3'h6;
	// Midscale code in two's complement
	localparam logic [15:0] MIDSCALE_CODE = 16'h0000;
	// Wake time and its cycle count at 50 MHz
	localparam int WAKE_TIME_US = 300;
	localparam int CLOCK_MHZ = 50;
	localparam int WAKE_CYCLES = WAKE_TIME_US * CLOCK_MHZ;

	// Power state of the whole device
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_DOWN = 2'b01,
		PWR_WAKING = 2'b10
	} power_state_t;

	// Per-channel analog control sent to the output stage
	typedef struct packed {
		logic outputOn;
		logic residualOn;
		logic agingRisk;
		logic [3:0] sleepBias;
	} chan_ctrl_t;
endpackage

/* File: hw/dac_channel_gate.sv */
`timescale 1ns/1ps
`default_nettype none
// One channel: gating and analog control decode
module dac_channel_gate #(
	parameter int DATA_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic gatePinSync,
	input wire logic gateReg,
	input wire logic [2:0] outputWaveformSelect,
	input wire logic silentGateControl,
	input wire logic [1:0] elementMatchingSetting,
	input wire logic [1:0] ditherSetting,
	input wire logic powerDown,
	input wire logic [3:0] sleepBiasCurrent,
	input wire logic [DATA_W-1:0] sampleIn,
	output logic [DATA_W-1:0] sampleOut,
	output dac_sleep_pkg::chan_ctrl_t ctrl
);
	// Channel passes only when pin and register both enable
	logic gateOpen;
	logic chanDisabled;
	assign gateOpen = gatePinSync & gateReg; // [R10]
	assign chanDisabled = (outputWaveformSelect == dac_sleep_pkg::WAVE_DISABLED);

	// Sample register, forced midscale when gated
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sampleOut <= dac_sleep_pkg::MIDSCALE_CODE;
		end else if (!gateOpen) begin
			sampleOut <= dac_sleep_pkg::MIDSCALE_CODE; // [R5] [R10]
		end else begin
			sampleOut <= sampleIn;
		end
	end

	// Analog control; residual kept in power down, disable and non-silent gating to avoid aging
	// Gating is checked before the waveform disable so silent gating wins on a disabled channel
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl <= '0;
		end else begin
			ctrl.sleepBias <= sleepBiasCurrent;
			ctrl.outputOn <= !powerDown && !chanDisabled;
			if (powerDown) begin
				ctrl.residualOn <= 1'b1; // [R2]
			end else if (!gateOpen) begin
				ctrl.residualOn <= !silentGateControl; // [R6] [R7]
			end else if (chanDisabled) begin
				ctrl.residualOn <= 1'b1; // [R4]
			end else begin
				ctrl.residualOn <= 1'b0;
			end
			// Quiet gating only safe with data independent settings
			ctrl.agingRisk <= !powerDown && !gateOpen && silentGateControl &&
				(elementMatchingSetting[1] || ditherSetting[1]); // [R7]
		end
	end
endmodule
`default_nettype wire

/* File: dv/dac_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side: register port, mode field, gate pins
module dac_host_model (
	input wire logic ref_clk,
	input wire logic [7:0] regRdata,
	output logic regWrite,
	output logic regRead,
	output logic [11:0] regAddr,
	output logic [7:0] regWdata,
	output logic [1:0] deviceMode,
	output logic [1:0] transmitGatePins
);
	// Quiet bus and open gates from time zero
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 12'h0000;
		regWdata = 8'h00;
		deviceMode = 2'h0;
		transmitGatePins = 2'h3;
	end
	// Sleep bias from termination current in uA, rounded up
	function automatic logic [3:0] biasFor(input int termUa);
		return 4'((2 * termUa - 7360 + 1469) / 1470);
	endfunction
	// One write; lines flipped after release so stale values never look valid
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask
	// One read; data picked up once it has settled
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		regAddr <= ~a;
		@(posedge ref_clk);
		#1;
		d = regRdata;
	endtask
	// Level controls change at the edge
	task automatic setPins(input logic [1:0] p);
		@(posedge ref_clk);
		transmitGatePins <= p;
	endtask
	task automatic setMode(input logic [1:0] m);
		@(posedge ref_clk);
		deviceMode <= m;
	endtask
endmodule
`default_nettype wire

/* File: dv/dac_sleep_output_disable_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_sleep_output_disable_tb_top;
	localparam int WAKE = 20; // Shortened wake count
	logic ref_clk = 1'b0, rst = 1'b1, regWrite, regRead, silentGateControl = 1'b0, powerDown, outputReady;
	logic [11:0] regAddr;
	logic [7:0] regWdata, regRdata;
	logic [1:0] deviceMode, transmitGatePins, gateRegBits = 2'h3, elementMatchingSetting = 2'h0, ditherSetting = 2'h0;
	logic [2:0] outputWaveformSelectA = 3'h0, outputWaveformSelectB = 3'h0;
	logic [15:0] sampleA = 16'h0000, sampleB = 16'h0000, codeA, codeB;
	dac_sleep_pkg::chan_ctrl_t ctrlA, ctrlB;
	int err_count = 0, checks = 0, cycles = 0;
	always #10 ref_clk = ~ref_clk;
	dac_host_model host (.ref_clk, .regRdata, .regWrite, .regRead, .regAddr, .regWdata, .deviceMode, .transmitGatePins);
	dac_sleep_output_disable #(.WAKE_COUNT(WAKE)) dut (.ref_clk, .rst, .regWrite, .regRead, .regAddr, .regWdata,
		.regRdata, .deviceMode, .outputWaveformSelectA, .outputWaveformSelectB, .gateRegBits, .silentGateControl,
		.elementMatchingSetting, .ditherSetting, .transmitGatePins, .sampleA, .sampleB, .codeA, .codeB, .ctrlA,
		.ctrlB, .powerDown, .outputReady);
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	// Bias registers: reset, write, read back, unmapped read
	task automatic testRegs();
		logic [7:0] d;
		logic [3:0] b;
		b = host.biasFor(10000);
		host.rd(dac_sleep_pkg::SLEEP_BIAS_A_ADDR, d);
		chk(d, 16'h0000, "bias A reset");
		host.wr(dac_sleep_pkg::SLEEP_BIAS_A_ADDR, {b, 4'h0});
		host.wr(dac_sleep_pkg::SLEEP_BIAS_B_ADDR, 8'h5a);
		host.rd(dac_sleep_pkg::SLEEP_BIAS_A_ADDR, d);
		chk(d, {8'h00, b, 4'h0}, "bias A readback");
		host.rd(dac_sleep_pkg::SLEEP_BIAS_B_ADDR, d);
		chk(d, 16'h005a, "bias B readback");
		host.rd(12'h0725, d);
		chk(d, 16'h0000, "unmapped read");
		chk(ctrlA.sleepBias, b, "bias A field");
		chk(ctrlB.sleepBias, 16'h0005, "bias B field");
	endtask
	// Gating by register bit and pin, plain and silent
	task automatic testGate();
		@(posedge ref_clk);
		sampleA <= 16'h1234;
		sampleB <= 16'h8765;
		tick();
		chk(codeA, 16'h1234, "open A passes");
		@(posedge ref_clk);
		gateRegBits <= 2'h2;
		tick();
		chk(codeA, dac_sleep_pkg::MIDSCALE_CODE, "reg gate midscale");
		chk(codeB, 16'h8765, "B unaffected");
		tick();
		chk(ctrlA.residualOn, 16'h0001, "plain gate residual");
		host.setPins(2'h1);
		repeat (3) tick();
		chk(codeB, dac_sleep_pkg::MIDSCALE_CODE, "pin gate midscale");
		@(posedge ref_clk);
		silentGateControl <= 1'b1;
		elementMatchingSetting <= 2'h2;
		ditherSetting <= 2'h3;
		repeat (2) tick();
		chk(ctrlA.residualOn, 16'h0000, "silent no residual");
		chk(ctrlA.agingRisk, 16'h0001, "aging flagged");
		@(posedge ref_clk);
		elementMatchingSetting <= 2'h1;
		ditherSetting <= 2'h1;
		repeat (2) tick();
		chk(ctrlA.agingRisk, 16'h0000, "aging clear");
		@(posedge ref_clk);
		gateRegBits <= 2'h3;
		silentGateControl <= 1'b0;
		host.setPins(2'h3);
		repeat (4) tick();
	endtask
	// One channel disabled by waveform code
	task automatic testWave();
		@(posedge ref_clk);
		outputWaveformSelectA <= dac_sleep_pkg::WAVE_DISABLED;
		repeat (2) tick();
		chk(ctrlA.outputOn, 16'h0000, "A disabled");
		chk(ctrlA.residualOn, 16'h0001, "A residual");
		chk(ctrlB.outputOn, 16'h0001, "B still on");
		@(posedge ref_clk);
		gateRegBits <= 2'h2;
		silentGateControl <= 1'b1;
		repeat (2) tick();
		chk(ctrlA.residualOn, 16'h0000, "silent disabled A");
		chk(ctrlA.outputOn, 16'h0000, "A still disabled");
		@(posedge ref_clk);
		gateRegBits <= 2'h3;
		silentGateControl <= 1'b0;
		outputWaveformSelectA <= 3'h0;
		outputWaveformSelectB <= dac_sleep_pkg::WAVE_DISABLED;
		repeat (2) tick();
		chk(ctrlB.outputOn, 16'h0000, "B disabled");
		chk(ctrlA.outputOn, 16'h0001, "A back on");
		@(posedge ref_clk);
		outputWaveformSelectB <= 3'h0;
	endtask
	// Full power down and the wake wait
	task automatic testPower();
		host.setMode(dac_sleep_pkg::MODE_POWER_DOWN);
		tick();
		chk(powerDown, 16'h0001, "powered down");
		chk(outputReady, 16'h0000, "not ready");
		tick();
		chk({ctrlA.residualOn, ctrlB.residualOn}, 16'h0003, "residual in sleep");
		host.setMode(2'h0);
		tick();
		chk(powerDown, 16'h0000, "left power down");
		repeat (WAKE - 1) tick();
		chk(outputReady, 16'h0000, "still waking");
		tick();
		chk(outputReady, 16'h0001, "awake");
	endtask
	task automatic summarize();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		testRegs();
		testGate();
		testWave();
		testPower();
		summarize();
	end
endmodule
`default_nettype wire
